//--- include/hcc_pkg.sv
// Purpose: Shared constants and types for the hex colour chain driver.
// Assumes: System clock of 200 MHz; characters arrive as 8-bit ASCII codes.
// Notes: Timing figures are kept in their own units and turned into cycle counts here.

`default_nettype none

package hcc_pkg;

	// Clock rate.
	localparam int unsigned SYS_CLK_MHZ = 200;

	// Chain timing, in nanoseconds and microseconds, and the derived cycle counts (least times round up).
	localparam int unsigned SHIFT_HALF_NS = 100;
	localparam int unsigned LATCH_HIGH_NS = 200;
	localparam int unsigned ACT_OFF_US = 10;
	localparam int unsigned SHIFT_HALF_CYC = (SHIFT_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned LATCH_HIGH_CYC = (LATCH_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned ACT_OFF_CYC = ACT_OFF_US * SYS_CLK_MHZ;
	localparam int unsigned CNT_W = 12;

	// Precision and word layout.
	localparam logic [4:0] BITS_MIN = 5'h01;
	localparam logic [4:0] BITS_MAX = 5'h10;
	localparam logic [4:0] BITS_DEFAULT = 5'h08;
	localparam logic [4:0] CHAN_BITS = 5'h0A;
	localparam int unsigned ACC_W = 16;
	localparam int unsigned WORD_BITS = 32;
	localparam logic [1:0] CMD_COLOUR = 2'h0;
	localparam logic [5:0] LAST_BIT = 6'h1F;

	// Character codes.
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UF = 8'h46;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LF_HEX = 8'h66;
	localparam logic [3:0] HEX_ALPHA_BASE = 4'hA;

	// Sequencer modes of the chain side.
	typedef enum logic [1:0] {
		HCC_IDLE,
		HCC_SHIFT_LO,
		HCC_SHIFT_HI,
		HCC_LATCH
	} hcc_mode_t;

	// The four wires to the first module.
	typedef struct packed {
		logic enable_n;
		logic sclk;
		logic data;
		logic latch;
	} hcc_chain_t;

	// State of the logic on the link clock.
	typedef struct packed {
		logic [7:0] held;
		logic req;
		logic [1:0] ack_s;
		logic [1:0] echo_s;
		logic ready;
		logic [7:0] echo_char;
		logic echo_valid;
	} hcc_link_t;

	// State of the logic on the system clock.
	typedef struct packed {
		logic [1:0] req_s;
		logic seen;
		logic [4:0] cfg_s1;
		logic [4:0] cfg_s2;
		hcc_mode_t mode;
		logic [ACC_W-1:0] acc;
		logic [2:0] ndig;
		logic [1:0] comp;
		logic [9:0] red;
		logic [9:0] green;
		logic [WORD_BITS-1:0] word;
		logic [5:0] bitn;
		logic [CNT_W-1:0] div;
		logic [CNT_W-1:0] act;
		logic led;
		hcc_chain_t chain;
	} hcc_sys_t;

endpackage : hcc_pkg

`default_nettype wire

//--- hw/hcc_driver.sv
// Purpose: Turns a stream of hex colour characters into serial words for a chain of RGB LED modules.
// Assumes: Characters arrive on the link clock with a valid/ready handshake; the link clock runs freely.
// Notes: One character crosses at a time by a toggle handshake, so the link is stalled while a word shifts.
//
// Operation
// - Drive enable, shift clock, serial data and latch wires to the first chain module.
// - Precision per channel is settable from 1 to 16 bits, default 8.
// - Components arrive red, then green, then blue, for each colour command.
// - Rescale each component to 10 bits as it completes; after a full triple, shift the colour out.
// - Line feed or carriage return pulses the latch so all modules update together.
// - Each complete colour shifts out without latching, so commands accumulate down the chain.
// - With precision 10, three digits per component and nine per colour are expected.
// - Echo every received character unless echo is switched off.
// - Activity indicator stays on and goes briefly off whenever a character arrives.

`timescale 1ns/1ps
`default_nettype none

module hcc_driver (
	// System clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Character link, on its own clock.
	input wire logic link_clk,
	input wire logic [7:0] rx_char,
	input wire logic rx_valid,
	output logic rx_ready,
	output logic [7:0] echo_char,
	output logic echo_valid,
	// Settings.
	input wire logic [4:0] input_bits,
	input wire logic echo_on,
	// Chain wires.
	output logic enable_out_pin,
	output logic shift_clock_out_pin,
	output logic serial_out_pin,
	output logic latch_out_pin,
	// Activity indicator, high means lit.
	output logic activity_led
);

	// Refused while elaborating, since a count that wraps would shorten every pulse silently.
	if (hcc_pkg::ACT_OFF_CYC >= (1 << hcc_pkg::CNT_W) || hcc_pkg::LATCH_HIGH_CYC < 1 ||
	    hcc_pkg::SHIFT_HALF_CYC < 1) begin : g_timing_check
		$error("hcc_driver: timing counts do not fit the counters.");
	end

	localparam logic [hcc_pkg::CNT_W-1:0] HALF_LOAD = hcc_pkg::CNT_W'(hcc_pkg::SHIFT_HALF_CYC - 1);
	localparam logic [hcc_pkg::CNT_W-1:0] LATCH_LOAD = hcc_pkg::CNT_W'(hcc_pkg::LATCH_HIGH_CYC - 1);
	localparam logic [hcc_pkg::CNT_W-1:0] ACT_LOAD = hcc_pkg::CNT_W'(hcc_pkg::ACT_OFF_CYC - 1);

	// Precision outside the legal range falls back to the default rather than stalling the decoder.
	function automatic logic [4:0] eff_bits(input logic [4:0] b);
		if (b < hcc_pkg::BITS_MIN || b > hcc_pkg::BITS_MAX) begin
			return hcc_pkg::BITS_DEFAULT;
		end
		return b;
	endfunction : eff_bits

	// Number of hex digits that make one component.
	function automatic logic [2:0] digits_for(input logic [4:0] b);
		logic [5:0] t;
		t = {1'b0, b} + 6'h03;
		return t[4:2];
	endfunction : digits_for

	// Mask to the chosen precision, then shift up or down onto the 10-bit channel.
	function automatic logic [9:0] scale(input logic [hcc_pkg::ACC_W-1:0] v, input logic [4:0] b);
		logic [16:0] mask;
		logic [hcc_pkg::ACC_W-1:0] m;
		logic [hcc_pkg::ACC_W-1:0] t;
		mask = (17'h00001 << b) - 17'h00001;
		m = v & mask[hcc_pkg::ACC_W-1:0];
		if (b <= hcc_pkg::CHAN_BITS) begin
			t = m << (hcc_pkg::CHAN_BITS - b);
		end else begin
			t = m >> (b - hcc_pkg::CHAN_BITS);
		end
		return t[9:0];
	endfunction : scale

	// Returns one when the code is a hex digit, with its value.
	function automatic logic hex_value(input logic [7:0] c, output logic [3:0] nib);
		logic [7:0] d;
		nib = 4'h0;
		d = 8'h00;
		if (c >= hcc_pkg::CH_0 && c <= hcc_pkg::CH_9) begin
			d = c - hcc_pkg::CH_0;
			nib = d[3:0];
			return 1'b1;
		end
		if (c >= hcc_pkg::CH_UA && c <= hcc_pkg::CH_UF) begin
			d = c - hcc_pkg::CH_UA;
			nib = d[3:0] + hcc_pkg::HEX_ALPHA_BASE;
			return 1'b1;
		end
		if (c >= hcc_pkg::CH_LA && c <= hcc_pkg::CH_LF_HEX) begin
			d = c - hcc_pkg::CH_LA;
			nib = d[3:0] + hcc_pkg::HEX_ALPHA_BASE;
			return 1'b1;
		end
		return 1'b0;
	endfunction : hex_value

	hcc_pkg::hcc_link_t lk;
	hcc_pkg::hcc_link_t next_lk;
	hcc_pkg::hcc_sys_t st;
	hcc_pkg::hcc_sys_t next_st;
	logic [1:0] lrst_s;

	// Reset reaches the link side through two flops; the link clock must tick while reset is held.
	always_ff @(posedge link_clk) begin
		lrst_s <= {lrst_s[0], sys_rst};
	end

	// Link side: hold one character, toggle the request, echo it.
	always_comb begin
		logic take;
		take = 1'b0;
		next_lk = lk;
		next_lk.ack_s = {lk.ack_s[0], st.seen};
		next_lk.echo_s = {lk.echo_s[0], echo_on};
		take = rx_valid && lk.ready;
		next_lk.echo_valid = 1'b0;
		if (take) begin
			next_lk.held = rx_char;
			next_lk.req = ~lk.req;
			next_lk.echo_char = rx_char;
			next_lk.echo_valid = lk.echo_s[1];
		end
		// Ready waits for the acknowledge, so a character is never overwritten before the system side took it.
		next_lk.ready = !take && (lk.req == lk.ack_s[1]);
	end

	always_ff @(posedge link_clk) begin
		if (lrst_s[1]) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// System side: decode, rescale, shift and latch.
	always_comb begin
		logic take;
		logic is_hex;
		logic [3:0] nib;
		logic [4:0] bits;
		logic [hcc_pkg::ACC_W-1:0] acc_n;
		logic [9:0] blue;
		take = 1'b0;
		is_hex = 1'b0;
		nib = 4'h0;
		bits = 5'h00;
		acc_n = '0;
		blue = 10'h000;
		next_st = st;
		next_st.req_s = {st.req_s[0], lk.req};
		next_st.cfg_s1 = input_bits;
		next_st.cfg_s2 = st.cfg_s1;
		bits = eff_bits(st.cfg_s2);
		next_st.chain.enable_n = 1'b0;
		if (st.act != '0) begin
			next_st.act = st.act - 1'b1;
		end else begin
			next_st.led = 1'b1;
		end
		// Characters are taken only while idle; the unanswered handshake stalls the link meanwhile.
		take = (st.req_s[1] != st.seen) && (st.mode == hcc_pkg::HCC_IDLE);
		unique case (st.mode)
			hcc_pkg::HCC_IDLE: begin
				if (take) begin
					next_st.seen = st.req_s[1];
					next_st.led = 1'b0;
					next_st.act = ACT_LOAD;
					is_hex = hex_value(lk.held, nib);
					if (is_hex) begin
						acc_n = {st.acc[hcc_pkg::ACC_W-5:0], nib};
						next_st.acc = acc_n;
						if (st.ndig + 3'h1 >= digits_for(bits)) begin
							next_st.acc = '0;
							next_st.ndig = 3'h0;
							unique case (st.comp)
								2'h0: begin
									next_st.red = scale(acc_n, bits);
									next_st.comp = 2'h1;
								end
								2'h1: begin
									next_st.green = scale(acc_n, bits);
									next_st.comp = 2'h2;
								end
								default: begin
									blue = scale(acc_n, bits);
									next_st.comp = 2'h0;
									next_st.word = {hcc_pkg::CMD_COLOUR, blue, st.red, st.green};
									next_st.chain.data = hcc_pkg::CMD_COLOUR[1];
									next_st.bitn = 6'h00;
									next_st.div = HALF_LOAD;
									next_st.mode = hcc_pkg::HCC_SHIFT_LO;
								end
							endcase
						end else begin
							next_st.ndig = st.ndig + 3'h1;
						end
					end else if (lk.held == hcc_pkg::CH_LF || lk.held == hcc_pkg::CH_CR) begin
						next_st.chain.latch = 1'b1;
						next_st.div = LATCH_LOAD;
						next_st.mode = hcc_pkg::HCC_LATCH;
					end
					// Any other code leaves the partial colour untouched.
				end
			end
			hcc_pkg::HCC_SHIFT_LO: begin
				if (st.div == '0) begin
					next_st.chain.sclk = 1'b1;
					next_st.div = HALF_LOAD;
					next_st.mode = hcc_pkg::HCC_SHIFT_HI;
				end else begin
					next_st.div = st.div - 1'b1;
				end
			end
			hcc_pkg::HCC_SHIFT_HI: begin
				if (st.div == '0) begin
					next_st.chain.sclk = 1'b0;
					next_st.div = HALF_LOAD;
					if (st.bitn == hcc_pkg::LAST_BIT) begin
						next_st.mode = hcc_pkg::HCC_IDLE;
					end else begin
						next_st.word = {st.word[hcc_pkg::WORD_BITS-2:0], 1'b0};
						next_st.chain.data = st.word[hcc_pkg::WORD_BITS-2];
						next_st.bitn = st.bitn + 6'h01;
						next_st.mode = hcc_pkg::HCC_SHIFT_LO;
					end
				end else begin
					next_st.div = st.div - 1'b1;
				end
			end
			hcc_pkg::HCC_LATCH: begin
				if (st.div == '0) begin
					next_st.chain.latch = 1'b0;
					next_st.mode = hcc_pkg::HCC_IDLE;
				end else begin
					next_st.div = st.div - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
			st.led <= 1'b1;
			st.mode <= hcc_pkg::HCC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign rx_ready = lk.ready;
	assign echo_char = lk.echo_char;
	assign echo_valid = lk.echo_valid;
	assign enable_out_pin = st.chain.enable_n;
	assign shift_clock_out_pin = st.chain.sclk;
	assign serial_out_pin = st.chain.data;
	assign latch_out_pin = st.chain.latch;
	assign activity_led = st.led;

endmodule : hcc_driver

`default_nettype wire

//--- dv/hcc_chain_model.sv
// Purpose: Behavioural model of a chain of two RGB LED modules.
// Assumes: Data is taken on the rising shift clock; latch copies on its rising edge.
// Notes: Outputs read zero while enable is high, as a real module goes dark.
`timescale 1ns/1ps
`default_nettype none
module hcc_chain_model (
	// Chain wires.
	input wire logic chain_enable_in,
	input wire logic chain_clock_in,
	input wire logic chain_serial_in,
	input wire logic chain_latch_in,
	// Latched words of the first and second module.
	output logic [31:0] near_word,
	output logic [31:0] far_word
);
	logic [63:0] sr = 64'h0;
	logic [63:0] held = 64'h0;
	always @(posedge chain_clock_in) begin
		sr <= {sr[62:0], chain_serial_in};
	end
	always @(posedge chain_latch_in) begin
		held <= sr;
	end
	assign near_word = chain_enable_in ? 32'h0 : held[31:0];
	assign far_word = chain_enable_in ? 32'h0 : held[63:32];
endmodule : hcc_chain_model
`default_nettype wire

//--- dv/hcc_driver_props.sv
// Purpose: Timing checks on the chain wires and the character link.
// Assumes: Echo setting is changed only while the link is quiet.
// Notes: The indicator check uses a counter, as its low time is long.
`timescale 1ns/1ps
`default_nettype none
module hcc_driver_props (
	// Clocks and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	// Link.
	input wire logic [7:0] rx_char,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] echo_char,
	input wire logic echo_valid,
	input wire logic echo_on,
	// Chain and indicator.
	input wire logic enable_out_pin,
	input wire logic shift_clock_out_pin,
	input wire logic serial_out_pin,
	input wire logic latch_out_pin,
	input wire logic activity_led
);
	logic [11:0] low_n;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || activity_led) low_n <= 12'h000;
		else if (low_n != 12'hFFF) low_n <= low_n + 12'h001;
	end
	AST_ENABLE_LOW: assert property (@(posedge sys_clk) disable iff (sys_rst) !enable_out_pin)
		else $error("chain enable left its active level");
	AST_LATCH_WIDTH: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(latch_out_pin) |-> ##39 latch_out_pin ##1 !latch_out_pin) else $error("latch pulse width wrong");
	AST_SCLK_HIGH: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(shift_clock_out_pin) |-> ##19 shift_clock_out_pin ##1 !shift_clock_out_pin)
		else $error("shift clock high time wrong");
	AST_DATA_STABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
		shift_clock_out_pin && $past(shift_clock_out_pin) |-> $stable(serial_out_pin))
		else $error("data moved while clock high");
	AST_NO_LATCH_IN_SHIFT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(latch_out_pin && shift_clock_out_pin)) else $error("latch during shift");
	AST_LED_OFF_TIME: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(activity_led) |-> low_n >= 12'h7CF) else $error("indicator off time too short");
	AST_READY_DROPS: assert property (@(posedge link_clk) disable iff (sys_rst)
		rx_valid && rx_ready |=> !rx_ready) else $error("ready held after accept");
	AST_ECHO_SAME: assert property (@(posedge link_clk) disable iff (sys_rst)
		rx_valid && rx_ready && echo_on && $past(echo_on, 3) |=> echo_valid && echo_char == $past(rx_char))
		else $error("echo missing or wrong");
	AST_ECHO_CAUSE: assert property (@(posedge link_clk) disable iff (sys_rst)
		echo_valid |-> $past(rx_valid && rx_ready)) else $error("echo without accept");
endmodule : hcc_driver_props
`default_nettype wire

//--- dv/test_hcc_driver.sv
// Purpose: Self-checking bench for the hex colour chain driver.
// Assumes: Scaling to 10 bits is by a power-of-two factor.
// Notes: The link side takes reset through two flops of its own, so the first character waits on the link clock.
`timescale 1ns/1ps
`default_nettype none
module test_hcc_driver;
	logic sys_clk = 1'b0, sys_rst = 1'b1, link_clk = 1'b0, rx_valid = 1'b0, echo_on = 1'b1;
	logic [7:0] rx_char = 8'h00;
	logic [4:0] input_bits = 5'h08;
	logic rx_ready, echo_valid, enable_out_pin, shift_clock_out_pin, serial_out_pin, latch_out_pin, activity_led;
	logic [7:0] echo_char;
	logic [31:0] near_word, far_word;
	int errors = 0, checks = 0, echoes = 0;
	always #2.5 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #32 link_clk = ~link_clk;
	end
	always @(posedge link_clk) if (echo_valid === 1'b1) echoes++;
	hcc_driver hcc_driver_inst (.sys_clk, .sys_rst, .link_clk, .rx_char, .rx_valid, .rx_ready, .echo_char,
		.echo_valid, .input_bits, .echo_on, .enable_out_pin, .shift_clock_out_pin, .serial_out_pin,
		.latch_out_pin, .activity_led);
	hcc_chain_model hcc_chain_model_inst (.chain_enable_in(enable_out_pin), .chain_clock_in(shift_clock_out_pin),
		.chain_serial_in(serial_out_pin), .chain_latch_in(latch_out_pin), .near_word, .far_word);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] word(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
		return {2'h0, b, r, g};
	endfunction : word
	task send(input string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			@(posedge link_clk);
			rx_char <= s[i];
			rx_valid <= 1'b1;
			n = 0;
			do @(posedge link_clk); while (rx_ready !== 1'b1 && n++ < 5000);
			if (n >= 5000) errors++;
			rx_valid <= 1'b0;
		end
		// Ready returns only once the system side has taken the last code; then a shift or latch may still run.
		n = 0;
		do @(posedge link_clk); while (rx_ready !== 1'b1 && n++ < 5000);
		if (n >= 5000) errors++;
		repeat (1300) @(posedge sys_clk);
	endtask : send
	task t_white;
		int e;
		e = echoes;
		send("ffffff\r");
		chk(near_word, word(10'h3FC, 10'h3FC, 10'h3FC));
		chk(32'(echoes - e), 32'h7);
		chk(activity_led, 1'b0);
		$display("white done");
	endtask : t_white
	task t_accum;
		send("ff0000");
		send("00ff00");
		repeat (1400) @(posedge sys_clk);
		chk(near_word, word(10'h3FC, 10'h3FC, 10'h3FC));
		chk(activity_led, 1'b1);
		send("\n");
		chk(near_word, word(10'h000, 10'h3FC, 10'h000));
		chk(far_word, word(10'h3FC, 10'h000, 10'h000));
		$display("accumulate done");
	endtask : t_accum
	task t_ten;
		int e;
		@(posedge sys_clk);
		input_bits <= 5'h0A;
		echo_on <= 1'b0;
		repeat (10) @(posedge link_clk);
		e = echoes;
		send("3ff001z000\r");
		chk(near_word, word(10'h3FF, 10'h001, 10'h000));
		chk(far_word, word(10'h000, 10'h3FC, 10'h000));
		chk(32'(echoes - e), 32'h0);
		@(posedge sys_clk);
		echo_on <= 1'b1;
		$display("ten bit done");
	endtask : t_ten
	task t_prec;
		int p;
		string s;
		logic [9:0] v;
		for (int k = 0; k < 4; k++) begin
			p = (k == 0) ? 1 : k * 4 + ((k == 1) ? 0 : 4);
			@(posedge sys_clk);
			input_bits <= 5'(p);
			repeat (8) @(posedge sys_clk);
			s = "";
			repeat (3 * ((p + 3) / 4)) s = {s, "f"};
			v = p < 10 ? 10'(((1 << p) - 1) << (10 - p)) : 10'(((1 << p) - 1) >> (p - 10));
			send({s, "\r"});
			chk(near_word, word(v, v, v));
		end
		$display("precision done");
	endtask : t_prec
	task print_verdict;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#300000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (10) @(posedge link_clk);
		t_white();
		t_accum();
		t_ten();
		t_prec();
		print_verdict();
	end
endmodule : test_hcc_driver
bind hcc_driver hcc_driver_props hcc_driver_props_inst (.sys_clk, .sys_rst, .link_clk, .rx_char, .rx_valid,
	.rx_ready, .echo_char, .echo_valid, .echo_on, .enable_out_pin, .shift_clock_out_pin, .serial_out_pin,
	.latch_out_pin, .activity_led);
`default_nettype wire
